// ==== pkg/drive_setpoint_map.svh ====
// Constants for the setpoint and run-behaviour controller
`ifndef DRIVE_SETPOINT_MAP_SVH
`define DRIVE_SETPOINT_MAP_SVH
// Clock rate and tick derivation (100 ms tick for 0.1 s units)
`define CLK_HZ            125000000
`define TICK_MS           100
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
// Restart delay in tenths of a second
`define RESTART_DLY_MAX   16'd200
// Brake start voltage in volts
`define BRAKE_V_MIN       10'd630
`define BRAKE_V_MAX       10'd710
// Brake rate in tenths of a percent
`define BRAKE_RATE_MAX    10'd1000
// Ramp times in tenths of a second
`define RAMP_T_MIN        16'd1
`define RAMP_T_MAX        16'd36000
`define JOG_T_MAX         16'd200
// Frequencies in hundredths of a hertz
`define FREQ_MAX          16'd40000
`define JOG_F_MIN         16'd100
`define JOG_F_MAX         16'd6000
// Parameter write indices
`define IDX_RESTART_DLY   6'd0
`define IDX_BRAKE_V       6'd1
`define IDX_BRAKE_RATE    6'd2
`define IDX_JOG_ACC       6'd3
`define IDX_JOG_DEC       6'd4
`define IDX_JOG_FREQ      6'd5
`define IDX_ACC_BASE      6'd8
`define IDX_DEC_BASE      6'd12
`define IDX_PRESET_BASE   6'd16
// Reset values
`define RST_BRAKE_V       10'd700
`define RST_RAMP_T        16'd100
`define RST_JOG_T         16'd60
`define RST_JOG_F         16'd500
`define RST_BRAKE_RATE    10'd1000
`endif

// ==== pkg/drive_setpoint_pkg.sv ====
// Types for the setpoint and run-behaviour controller
package drive_setpoint_pkg;
    typedef enum logic [1:0] {LOW_UNDEFINED, LOW_RUN_AT_LIMIT, LOW_STOP} below_limit_mode_t;
    typedef enum logic [1:0] {CMD_KEYPAD, CMD_TERMINAL, CMD_HOST} cmd_source_t;
    typedef struct packed {
        logic        valid;
        logic [5:0]  index;
        logic [15:0] value;
    } param_write_t;
    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] accTime;
        logic [15:0] decTime;
        logic [15:0] sStart;
        logic [15:0] sRise;
        logic        run;
    } ramp_cmd_t;
endpackage

// ==== design/preset_store.sv ====
// Small register memory for preset speed frequencies
`timescale 1ns/1ps
`default_nettype none
module preset_store #(
    parameter int DEPTH = 15,
    parameter int WIDTH = 16
) (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      writeEn,
    input  wire logic [3:0]                writeAddr,
    input  wire logic [WIDTH-1:0]          writeData,
    input  wire logic [3:0]                readAddr,
    output var  logic [WIDTH-1:0]          readData
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // Storage entries, cleared at reset
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                mem_q[i] <= '0;
            end else if (writeEn && writeAddr == 4'(i)) begin
                mem_q[i] <= writeData;
            end
        end
    end

    // Registered read port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readData <= '0;
        end else if (readAddr < 4'(DEPTH)) begin
            readData <= mem_q[readAddr];
        end else begin
            readData <= '0;
        end
    end
endmodule
`default_nettype wire

// ==== design/drive_setpoint_control.sv ====
// Setpoint selection and run behaviour for a motor drive
`timescale 1ns/1ps
`default_nettype none
`include "drive_setpoint_map.svh"
module drive_setpoint_control #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic                              clock,
    input  wire logic                              rst_n,
    input  wire drive_setpoint_pkg::param_write_t  paramWrite,
    input  wire logic                              restartEnable,
    input  wire logic                              supplyOk,
    input  wire logic [9:0]                        busVoltage,
    input  wire logic [9:0]                        carrierPhase,
    input  wire logic [15:0]                       mainFreq,
    input  wire logic [15:0]                       lowLimit,
    input  wire drive_setpoint_pkg::below_limit_mode_t belowLimitMode,
    input  wire logic                              multiKeyMode,
    input  wire logic                              multi_function_key,
    input  wire logic [1:0]                        stopKeyMode,
    input  wire drive_setpoint_pkg::cmd_source_t   cmdSource,
    input  wire logic                              stopResetKey,
    input  wire logic                              fanMode,
    input  wire logic                              ramp_select_input_a,
    input  wire logic                              ramp_select_input_b,
    input  wire logic [3:0]                        presetCode,
    input  wire logic                              sequenceActive,
    input  wire logic [3:0]                        sequencePreset,
    input  wire logic                              runCommand,
    input  wire logic                              jogKeypad,
    input  wire logic                              jogTerminal,
    input  wire logic                              jogHost,
    input  wire logic [15:0]                       sStartIn,
    input  wire logic [15:0]                       sRiseIn,
    output var  drive_setpoint_pkg::ramp_cmd_t     rampCmd,
    output var  logic                              reverse_q,
    output var  logic                              brakeSwitch_q,
    output var  logic                              fanOn_q,
    output var  logic                              faultReset_q
);
    import drive_setpoint_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Parameter storage
    logic [15:0] restartDly_q, jogAcc_q, jogDec_q, jogFreq_q;
    logic [9:0]  brakeV_q, brakeRate_q;
    logic [15:0] accT_q [4];
    logic [15:0] decT_q [4];
    logic [5:0]  idx;
    logic [15:0] val;
    logic        rampOk, jogTOk, jogFOk, freqOk;

    // Range checks on incoming writes
    assign idx    = paramWrite.index;
    assign val    = paramWrite.value;
    assign rampOk = val >= `RAMP_T_MIN && val <= `RAMP_T_MAX;
    assign jogTOk = val >= `RAMP_T_MIN && val <= `JOG_T_MAX;
    assign jogFOk = val == 16'h0000 || (val >= `JOG_F_MIN && val <= `JOG_F_MAX);
    assign freqOk = val <= `FREQ_MAX;

    // Scalar parameters, writes outside range are dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            restartDly_q <= 16'h0000;
            brakeV_q     <= `RST_BRAKE_V;
            brakeRate_q  <= `RST_BRAKE_RATE;
            jogAcc_q     <= `RST_JOG_T;
            jogDec_q     <= `RST_JOG_T;
            jogFreq_q    <= `RST_JOG_F;
        end else if (paramWrite.valid) begin
            if (idx == `IDX_RESTART_DLY && val <= `RESTART_DLY_MAX) restartDly_q <= val;
            if (idx == `IDX_BRAKE_V && val >= 16'(`BRAKE_V_MIN) && val <= 16'(`BRAKE_V_MAX))
                brakeV_q <= val[9:0];
            if (idx == `IDX_BRAKE_RATE && val <= 16'(`BRAKE_RATE_MAX)) brakeRate_q <= val[9:0];
            if (idx == `IDX_JOG_ACC && jogTOk) jogAcc_q <= val;
            if (idx == `IDX_JOG_DEC && jogTOk) jogDec_q <= val;
            if (idx == `IDX_JOG_FREQ && jogFOk) jogFreq_q <= val;
        end
    end

    // Four ramp time pairs, set one plus three further sets
    for (genvar s = 0; s < 4; s++) begin : g_ramp
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                accT_q[s] <= `RST_RAMP_T;
                decT_q[s] <= `RST_RAMP_T;
            end else if (paramWrite.valid && rampOk) begin
                if (idx == `IDX_ACC_BASE + 6'(s)) accT_q[s] <= val;
                if (idx == `IDX_DEC_BASE + 6'(s)) decT_q[s] <= val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Preset store and selection
    logic       presetWrEn;
    logic [3:0] presetWrAddr, presetRdAddr, activePreset;
    logic [15:0] presetData;
    logic       presetSel_q;

    assign presetWrEn   = paramWrite.valid && freqOk && idx >= `IDX_PRESET_BASE
                          && idx < `IDX_PRESET_BASE + 6'd15;
    assign presetWrAddr = 4'(idx - `IDX_PRESET_BASE);
    assign activePreset = sequenceActive ? sequencePreset : presetCode;
    assign presetRdAddr = 4'(activePreset - 4'h1);

    preset_store #(.DEPTH(15), .WIDTH(16)) u_presets (
        .clock     (clock),
        .rst_n     (rst_n),
        .writeEn   (presetWrEn),
        .writeAddr (presetWrAddr),
        .writeData (val),
        .readAddr  (presetRdAddr),
        .readData  (presetData)
    );

    // Match the one-cycle read latency
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) presetSel_q <= 1'b0;
        else        presetSel_q <= activePreset != 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Restart after supply recovery
    typedef enum logic [1:0] {PW_UP, PW_LOST, PW_WAIT} power_state_t;
    power_state_t pwState_q;
    logic [15:0]  tenths_q;
    logic [31:0]  tickCnt_q;
    logic         tick, restartHold;

    assign tick = tickCnt_q == 32'(TICK_CYCLES - 1);
    assign restartHold = pwState_q != PW_UP;

    // Supply state and delay count in 0.1 s ticks
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwState_q <= PW_UP;
            tenths_q  <= 16'h0000;
            tickCnt_q <= 32'h0;
        end else begin
            tickCnt_q <= (pwState_q == PW_WAIT && !tick) ? tickCnt_q + 32'h1 : 32'h0;
            unique case (pwState_q)
                PW_UP:   if (!supplyOk) pwState_q <= PW_LOST;
                PW_LOST: if (supplyOk && restartEnable) begin
                    pwState_q <= PW_WAIT;
                    tenths_q  <= 16'h0000;
                end
                PW_WAIT: begin
                    if (!supplyOk) pwState_q <= PW_LOST;
                    else if (tenths_q >= restartDly_q) pwState_q <= PW_UP;
                    else if (tick) tenths_q <= tenths_q + 16'h1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Keys: direction reversal, stop and reset
    logic mfKey_q, stopKey_q, stopped_q, stopAllowed, keyPress, stopPress;

    assign keyPress    = multi_function_key && !mfKey_q;
    assign stopPress   = stopResetKey && !stopKey_q;
    assign stopAllowed = cmdSource == CMD_KEYPAD ||
                         (stopKeyMode == 2'd1 && cmdSource == CMD_HOST) ||
                         (stopKeyMode == 2'd2 && cmdSource == CMD_TERMINAL);

    // Edge detection and latched key effects
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mfKey_q      <= 1'b0;
            stopKey_q    <= 1'b0;
            reverse_q    <= 1'b0;
            stopped_q    <= 1'b0;
            faultReset_q <= 1'b0;
        end else begin
            mfKey_q      <= multi_function_key;
            stopKey_q    <= stopResetKey;
            faultReset_q <= stopPress;
            if (keyPress && multiKeyMode) reverse_q <= !reverse_q;
            if (stopPress && stopAllowed) stopped_q <= 1'b1;
            else if (!runCommand) stopped_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Setpoint and ramp command
    logic        jogReq, belowLow, runReq;
    logic [1:0]  rampSet;
    logic [15:0] baseFreq, runFreq;

    assign jogReq   = jogKeypad || jogTerminal || jogHost;
    assign rampSet  = {ramp_select_input_b, ramp_select_input_a};
    assign baseFreq = presetSel_q ? presetData : mainFreq;
    assign belowLow = baseFreq < lowLimit;
    assign runFreq  = (belowLow && belowLimitMode == LOW_RUN_AT_LIMIT) ? lowLimit : baseFreq;
    assign runReq   = (runCommand || jogReq) && !stopped_q && !restartHold
                      && !(belowLow && belowLimitMode == LOW_STOP && !jogReq);

    // Registered command to the ramp generator; times span 0.1 s to maximum
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rampCmd <= '0;
        end else begin
            rampCmd.run     <= runReq;
            rampCmd.freq    <= jogReq ? jogFreq_q : runFreq;
            rampCmd.accTime <= jogReq ? jogAcc_q : accT_q[rampSet];
            rampCmd.decTime <= jogReq ? jogDec_q : decT_q[rampSet];
            rampCmd.sStart  <= sStartIn;
            rampCmd.sRise   <= sRiseIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Dynamic brake and cooling fan
    logic brakeDue;
    assign brakeDue = brakeRate_q != 10'h000 && busVoltage >= brakeV_q
                      && carrierPhase < brakeRate_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            brakeSwitch_q <= 1'b0;
            fanOn_q       <= 1'b0;
        end else begin
            brakeSwitch_q <= brakeDue;
            fanOn_q       <= !fanMode || rampCmd.run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_restart_off;
        @(posedge clock) disable iff (!rst_n)
        (pwState_q == PW_LOST && supplyOk && !restartEnable) |=> pwState_q == PW_LOST;
    endproperty
    a_restart_off: assert property (p_restart_off) else $error("restart while disabled");

    property p_delay;
        @(posedge clock) disable iff (!rst_n)
        (pwState_q == PW_WAIT && $past(pwState_q) == PW_WAIT && tenths_q < restartDly_q) |-> !rampCmd.run;
    endproperty
    a_delay: assert property (p_delay) else $error("ran during restart delay");

    property p_brake_off;
        @(posedge clock) disable iff (!rst_n)
        (brakeRate_q == 10'h000) |=> !brakeSwitch_q;
    endproperty
    a_brake_off: assert property (p_brake_off) else $error("brake with zero rate");

    property p_brake_v;
        @(posedge clock) disable iff (!rst_n)
        brakeSwitch_q |-> $past(busVoltage) >= $past(brakeV_q);
    endproperty
    a_brake_v: assert property (p_brake_v) else $error("brake below threshold");

    property p_reverse;
        @(posedge clock) disable iff (!rst_n)
        (keyPress && multiKeyMode) |=> reverse_q != $past(reverse_q);
    endproperty
    a_reverse: assert property (p_reverse) else $error("no reversal on key");

    property p_fan;
        @(posedge clock) disable iff (!rst_n)
        !fanMode |=> fanOn_q;
    endproperty
    a_fan: assert property (p_fan) else $error("fan off in always mode");

    property p_ramp_sel;
        @(posedge clock) disable iff (!rst_n)
        (!jogReq && rampSet == 2'd3) |=> rampCmd.accTime == $past(accT_q[3]);
    endproperty
    a_ramp_sel: assert property (p_ramp_sel) else $error("wrong ramp set");

    property p_range;
        @(posedge clock) disable iff (!rst_n)
        brakeV_q >= `BRAKE_V_MIN && brakeV_q <= `BRAKE_V_MAX && restartDly_q <= `RESTART_DLY_MAX;
    endproperty
    a_range: assert property (p_range) else $error("parameter out of range");
endmodule
`default_nettype wire

// ==== testbench/drive_operator_model.sv ====
// Operator side model: keypad, control terminals and host computer
`timescale 1ns/1ps
`default_nettype none
module drive_operator_model (
    input  wire logic                             clock,
    output var  drive_setpoint_pkg::param_write_t paramWrite,
    output var  logic                             multi_function_key,
    output var  logic                             stopResetKey,
    output var  logic                             jogKeypad,
    output var  logic                             jogTerminal,
    output var  logic                             jogHost,
    output var  logic [15:0]                      sStartIn,
    output var  logic [15:0]                      sRiseIn
);
    import drive_setpoint_pkg::*;
    // Idle levels; curve portions sum to 70 percent of the ramp
    initial begin
        paramWrite = '0;
        multi_function_key = 1'b0;
        stopResetKey = 1'b0;
        jogKeypad = 1'b0;
        jogTerminal = 1'b0;
        jogHost = 1'b0;
        sStartIn = 16'h00C8;
        sRiseIn = 16'h01F4;
    end
    ////////////////////////////////////////////////////////////////////////
    // One-cycle parameter write from the host
    task automatic writeParam(input logic [5:0] idx, input logic [15:0] val);
        @(posedge clock);
        #1;
        paramWrite = '{valid: 1'b1, index: idx, value: val};
        @(posedge clock);
        #1;
        paramWrite.valid = 1'b0;
    endtask
    // Key held for two cycles, then released
    task automatic pressKey(input logic stopKey);
        @(posedge clock);
        #1;
        if (stopKey) stopResetKey = 1'b1;
        else multi_function_key = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        stopResetKey = 1'b0;
        multi_function_key = 1'b0;
    endtask
    // Jog request from one of the three sources
    task automatic setJog(input logic [1:0] src, input logic on);
        @(posedge clock);
        #1;
        jogKeypad = (src == 2'd0) ? on : 1'b0;
        jogTerminal = (src == 2'd1) ? on : 1'b0;
        jogHost = (src == 2'd2) ? on : 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== testbench/drive_setpoint_control_tb_top.sv ====
// Self-checking bench for the setpoint and run-behaviour controller
`timescale 1ns/1ps
`default_nettype none
module drive_setpoint_control_tb_top;
    import drive_setpoint_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, restartEnable = 1'b0, supplyOk = 1'b1;
    logic [9:0] busVoltage = 10'h000, carrierPhase = 10'h000;
    logic [15:0] mainFreq = 16'h04D2, lowLimit = 16'h0000;
    below_limit_mode_t belowLimitMode = LOW_UNDEFINED;
    cmd_source_t cmdSource = CMD_KEYPAD;
    logic multiKeyMode = 1'b0, fanMode = 1'b0, runCommand = 1'b1, sequenceActive = 1'b0;
    logic [1:0] stopKeyMode = 2'h0;
    logic rampA = 1'b0, rampB = 1'b0;
    logic [3:0] presetCode = 4'h0, sequencePreset = 4'h0;
    param_write_t paramWrite;
    logic mfKey, stopKey, jogK, jogT, jogH, reverse_q, brakeSwitch_q, fanOn_q, faultReset_q;
    logic [15:0] sStartIn, sRiseIn;
    ramp_cmd_t rampCmd;
    int errorCnt = 0, testsRun = 0, pulseCnt = 0, c0;
    logic [15:0] accTab [4] = '{16'h0001, 16'h0016, 16'h0021, 16'h8CA0};
    cmd_source_t srcTab [6] = '{CMD_KEYPAD, CMD_TERMINAL, CMD_HOST, CMD_HOST, CMD_TERMINAL, CMD_TERMINAL};
    logic [1:0] modeTab [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1};
    logic stopTab [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    // Clock at 8 ns and key pulse counter
    initial forever #4 clock = ~clock;
    always @(posedge clock) if (faultReset_q === 1'b1) pulseCnt <= pulseCnt + 1;
    ////////////////////////////////////////////////////////////////////////
    drive_setpoint_control #(.TICK_CYCLES(4)) DUT (.clock(clock), .rst_n(rst_n), .paramWrite(paramWrite),
        .restartEnable(restartEnable), .supplyOk(supplyOk), .busVoltage(busVoltage),
        .carrierPhase(carrierPhase), .mainFreq(mainFreq), .lowLimit(lowLimit), .belowLimitMode(belowLimitMode),
        .multiKeyMode(multiKeyMode), .multi_function_key(mfKey), .stopKeyMode(stopKeyMode),
        .cmdSource(cmdSource), .stopResetKey(stopKey), .fanMode(fanMode), .ramp_select_input_a(rampA),
        .ramp_select_input_b(rampB), .presetCode(presetCode), .sequenceActive(sequenceActive),
        .sequencePreset(sequencePreset), .runCommand(runCommand), .jogKeypad(jogK), .jogTerminal(jogT),
        .jogHost(jogH), .sStartIn(sStartIn), .sRiseIn(sRiseIn), .rampCmd(rampCmd), .reverse_q(reverse_q),
        .brakeSwitch_q(brakeSwitch_q), .fanOn_q(fanOn_q), .faultReset_q(faultReset_q));
    drive_operator_model op (.clock(clock), .paramWrite(paramWrite), .multi_function_key(mfKey),
        .stopResetKey(stopKey), .jogKeypad(jogK), .jogTerminal(jogT), .jogHost(jogH),
        .sStartIn(sStartIn), .sRiseIn(sRiseIn));
    ////////////////////////////////////////////////////////////////////////
    // Comparison, pacing and reporting helpers
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic endTest(input string name);
        $display("test %s done, mismatches so far %0d", name, errorCnt);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic brakeCase(input logic [9:0] v, input logic [9:0] ph, input logic exp);
        busVoltage = v;
        carrierPhase = ph;
        tick(3);
        check("brake", 16'(brakeSwitch_q), 16'(exp));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        tick(3);
        rst_n = 1'b1;
        tick(3);
        check("freq", rampCmd.freq, 16'h04D2);
        check("acc", rampCmd.accTime, 16'h0064);
        check("sStart", rampCmd.sStart, 16'h00C8);
        check("sRise", rampCmd.sRise, 16'h01F4);
        check("run", 16'(rampCmd.run), 16'h0001);
        endTest("defaults");
        for (int i = 0; i < 4; i++) begin
            op.writeParam(6'(8 + i), accTab[i]);
            op.writeParam(6'(12 + i), 16'(16'h0100 + i));
        end
        op.writeParam(6'h08, 16'h0000);
        op.writeParam(6'h0B, 16'h8CA1);
        for (int i = 0; i < 4; i++) begin
            {rampB, rampA} = 2'(i);
            tick(3);
            check("acc set", rampCmd.accTime, accTab[i]);
            check("dec set", rampCmd.decTime, 16'(16'h0100 + i));
        end
        {rampB, rampA} = 2'b00;
        endTest("ramp sets");
        op.writeParam(6'h10, 16'h03E8);
        op.writeParam(6'h1E, 16'h9C40);
        op.writeParam(6'h1E, 16'h9C41);
        op.writeParam(6'h11, 16'h0000);
        presetCode = 4'h1;
        tick(3);
        check("preset 1", rampCmd.freq, 16'h03E8);
        presetCode = 4'hF;
        tick(3);
        check("preset 15", rampCmd.freq, 16'h9C40);
        presetCode = 4'h2;
        tick(3);
        check("preset 2", rampCmd.freq, 16'h0000);
        presetCode = 4'h0;
        sequenceActive = 1'b1;
        sequencePreset = 4'h1;
        tick(3);
        check("sequence", rampCmd.freq, 16'h03E8);
        sequenceActive = 1'b0;
        endTest("presets");
        op.writeParam(6'h03, 16'h0005);
        op.writeParam(6'h04, 16'h00C8);
        op.writeParam(6'h05, 16'h1770);
        op.writeParam(6'h05, 16'h0032);
        for (int s = 0; s < 3; s++) begin
            op.setJog(2'(s), 1'b1);
            tick(3);
            check("jog freq", rampCmd.freq, 16'h1770);
            check("jog acc", rampCmd.accTime, 16'h0005);
            check("jog dec", rampCmd.decTime, 16'h00C8);
            op.setJog(2'(s), 1'b0);
        end
        tick(3);
        check("after jog", rampCmd.freq, 16'h04D2);
        endTest("jog");
        lowLimit = 16'h07D0;
        belowLimitMode = LOW_RUN_AT_LIMIT;
        tick(3);
        check("at limit", rampCmd.freq, 16'h07D0);
        check("run limit", 16'(rampCmd.run), 16'h0001);
        belowLimitMode = LOW_STOP;
        tick(3);
        check("stop limit", 16'(rampCmd.run), 16'h0000);
        belowLimitMode = LOW_UNDEFINED;
        tick(3);
        check("base below limit", rampCmd.freq, 16'h04D2);
        check("run below limit", 16'(rampCmd.run), 16'h0001);
        lowLimit = 16'h0000;
        endTest("low limit");
        multiKeyMode = 1'b1;
        for (int k = 0; k < 3; k++) begin
            if (k == 2) multiKeyMode = 1'b0;
            op.pressKey(1'b0);
            tick(3);
            check("reverse", 16'(reverse_q), (k == 0) ? 16'h0001 : 16'h0000);
        end
        endTest("multi key");
        for (int k = 0; k < 6; k++) begin
            cmdSource = srcTab[k];
            stopKeyMode = modeTab[k];
            c0 = pulseCnt;
            op.pressKey(1'b1);
            tick(3);
            check("stop run", 16'(rampCmd.run), 16'(!stopTab[k]));
            check("reset pulse", 16'(pulseCnt - c0), 16'h0001);
            runCommand = 1'b0;
            tick(2);
            runCommand = 1'b1;
            tick(3);
            check("rerun", 16'(rampCmd.run), 16'h0001);
        end
        cmdSource = CMD_KEYPAD;
        endTest("stop key");
        for (int f = 0; f < 2; f++) begin
            fanMode = 1'(f);
            runCommand = 1'b0;
            tick(3);
            check("fan idle", 16'(fanOn_q), 16'(f == 0));
            runCommand = 1'b1;
            tick(3);
            check("fan run", 16'(fanOn_q), 16'h0001);
        end
        endTest("fan");
        brakeCase(10'h2BC, 10'h3E7, 1'b1);
        brakeCase(10'h2BB, 10'h000, 1'b0);
        op.writeParam(6'h01, 16'h0275);
        brakeCase(10'h2BB, 10'h000, 1'b0);
        op.writeParam(6'h01, 16'h0276);
        brakeCase(10'h276, 10'h000, 1'b1);
        brakeCase(10'h275, 10'h000, 1'b0);
        op.writeParam(6'h02, 16'h01F4);
        brakeCase(10'h2C6, 10'h1F3, 1'b1);
        brakeCase(10'h2C6, 10'h1F4, 1'b0);
        op.writeParam(6'h02, 16'h0000);
        op.writeParam(6'h02, 16'h03E9);
        brakeCase(10'h2C6, 10'h000, 1'b0);
        endTest("brake");
        op.writeParam(6'h00, 16'h0003);
        op.writeParam(6'h00, 16'h00C9);
        restartEnable = 1'b1;
        supplyOk = 1'b0;
        tick(3);
        check("outage", 16'(rampCmd.run), 16'h0000);
        supplyOk = 1'b1;
        tick(2);
        check("holding", 16'(rampCmd.run), 16'h0000);
        c0 = 2;
        while (rampCmd.run !== 1'b1 && c0 < 60) begin
            tick(1);
            c0++;
        end
        check("delay ok", 16'(c0 >= 8 && c0 <= 20), 16'h0001);
        endTest("restart");
        restartEnable = 1'b0;
        supplyOk = 1'b0;
        tick(3);
        supplyOk = 1'b1;
        tick(60);
        check("no restart", 16'(rampCmd.run), 16'h0000);
        endTest("no restart");
        summarize();
    end
endmodule
`default_nettype wire
